// *** logic/asc_scan_controller.sv ***
`default_nettype none
module asc_scan_controller (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [asc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [asc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [asc_pkg::DATA_W-1:0] regRdData,
    // Trigger sources, active low
    input wire logic timerTriggerA_n,
    input wire logic timerTriggerZero_n,
    input wire logic timerTriggerFourA_n,
    input wire logic timerTriggerFourB_n,
    input wire logic externalTriggerPin_n,
    // Analog front end
    input wire logic [asc_pkg::RES_W-1:0] adcData,
    output logic [asc_pkg::CHAN_W-1:0] adcChannel,
    output logic adcConvert,
    output logic [asc_pkg::CHAN_N-1:0] holdDedicated,
    output logic holdLowGroup,
    output logic holdHighGroup,
    // Interrupt
    output logic irq
);
    import asc_pkg::*;

    function automatic logic isResultAddr(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - RESULT_BASE_ADDR;
        isResultAddr = (a >= RESULT_BASE_ADDR) && (off[ADDR_W-1:RESULT_STRIDE_SHIFT] < CHAN_N)
            && (off[RESULT_STRIDE_SHIFT-1:0] == '0);
    endfunction

    function automatic logic [CHAN_W-1:0] resultIndex(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - RESULT_BASE_ADDR;
        resultIndex = off[RESULT_STRIDE_SHIFT+CHAN_W-1:RESULT_STRIDE_SHIFT];
    endfunction

    // Lowest selected channel at or above the given one
    function automatic logic [CHAN_W:0] findChannel(input logic [CHAN_N-1:0] mask,
                                                     input logic [CHAN_W:0] from);
        logic [CHAN_W:0] hit;
        hit = '0;
        for (int i = CHAN_N - 1; i >= 0; i--) begin
            if (mask[i] && (i >= int'(from))) begin
                hit = {1'b1, CHAN_W'(i)};
            end
        end
        findChannel = hit;
    endfunction

    asc_state_type state;
    asc_state_type next_state;
    logic startBit;
    logic next_startBit;
    logic scanMode;
    logic next_scanMode;
    logic autoClear;
    logic next_autoClear;
    logic endIntEnable;
    logic next_endIntEnable;
    logic trigEnable;
    logic next_trigEnable;
    logic endFlag;
    logic next_endFlag;
    logic [CHAN_N-1:0] chanMask;
    logic [CHAN_N-1:0] next_chanMask;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] next_irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] next_irqMask;
    logic [CNT_W-1:0] convCount;
    logic [CNT_W-1:0] next_convCount;
    logic [CHAN_W-1:0] next_adcChannel;
    logic next_adcConvert;
    logic [RES_W-1:0] result [CHAN_N];
    logic [RES_W-1:0] next_result [CHAN_N];
    logic [DATA_W-1:0] next_regRdData;
    logic next_irq;
    logic scanStart;
    logic trigPulse;

    asc_trigger_detect u_trigger (
        .core_clk(core_clk),
        .srst(srst),
        .trig_n({externalTriggerPin_n, timerTriggerFourB_n, timerTriggerFourA_n,
                 timerTriggerZero_n, timerTriggerA_n}),
        .trigPulse(trigPulse)
    );

    asc_hold_control u_hold (
        .core_clk(core_clk),
        .srst(srst),
        .scanStart(scanStart),
        .scanMask(chanMask),
        .sampleNow(next_adcConvert & (state == ASC_SAMPLE)),
        .sampleChannel(next_adcChannel),
        .holdDedicated(holdDedicated),
        .holdLowGroup(holdLowGroup),
        .holdHighGroup(holdHighGroup)
    );

    always_comb begin
        logic [CHAN_W:0] pick;
        logic scanEnd;
        logic trigLost;
        pick = '0;
        scanEnd = 1'b0;
        trigLost = 1'b0;
        scanStart = 1'b0;
        next_state = state;
        next_startBit = startBit;
        next_scanMode = scanMode;
        next_autoClear = autoClear;
        next_endIntEnable = endIntEnable;
        next_trigEnable = trigEnable;
        next_endFlag = endFlag;
        next_chanMask = chanMask;
        next_irqStatus = irqStatus;
        next_irqMask = irqMask;
        next_convCount = convCount;
        next_adcChannel = adcChannel;
        next_adcConvert = 1'b0;
        next_result = result;

        // Read side effect; a result landing in the same cycle still wins
        if (regRd && autoClear && isResultAddr(regAddr)) begin
            next_result[resultIndex(regAddr)] = '0;
        end

        // Triggers only count while enabled
        if (trigPulse && trigEnable) begin
            if (startBit) begin
                trigLost = 1'b1;
            end else begin
                next_startBit = 1'b1;
            end
        end

        case (state)
            ASC_IDLE: begin
                pick = findChannel(chanMask, '0);
                if (startBit && pick[CHAN_W]) begin
                    scanStart = 1'b1;
                    next_adcChannel = pick[CHAN_W-1:0];
                    next_adcConvert = 1'b1;
                    next_state = ASC_SAMPLE;
                end
            end
            ASC_SAMPLE: begin
                next_adcConvert = 1'b1;
                next_convCount = CONV_LAST;
                next_state = ASC_CONVERT;
            end
            ASC_CONVERT: begin
                next_adcConvert = 1'b1;
                if (convCount == '0) begin
                    next_result[adcChannel] = adcData;
                    pick = findChannel(chanMask, {1'b0, adcChannel} + 1'b1);
                    if (pick[CHAN_W]) begin
                        next_adcChannel = pick[CHAN_W-1:0];
                        next_state = ASC_SAMPLE;
                    end else begin
                        scanEnd = 1'b1;
                        next_adcConvert = 1'b0;
                        next_state = ASC_IDLE;
                        if (!scanMode) begin
                            next_startBit = 1'b0;
                        end
                    end
                end else begin
                    next_convCount = convCount - 1'b1;
                end
            end
            default: begin
                next_state = ASC_IDLE;
            end
        endcase

        // Start bit at zero halts any scan in progress
        if (!startBit && state != ASC_IDLE) begin
            next_state = ASC_IDLE;
            next_adcConvert = 1'b0;
        end

        if (regWr) begin
            case (regAddr)
                CONVERTER_CONTROL_ADDR: begin
                    next_startBit = regWrData[CTRL_START_BIT];
                    next_scanMode = regWrData[CTRL_SCAN_MODE_BIT];
                    next_autoClear = regWrData[CTRL_AUTOCLEAR_BIT];
                    next_endIntEnable = regWrData[CTRL_END_IE_BIT];
                    next_trigEnable = regWrData[CTRL_TRIG_EN_BIT];
                end
                SCAN_STATUS_ADDR: begin
                    if (!regWrData[STATUS_END_FLAG_BIT]) begin
                        next_endFlag = 1'b0;
                    end
                end
                CHANNEL_SELECT_MASK_ADDR: begin
                    next_chanMask = regWrData;
                end
                IRQ_STATUS_ADDR: begin
                    next_irqStatus = irqStatus & ~regWrData[IRQ_W-1:0];
                end
                IRQ_MASK_ADDR: begin
                    next_irqMask = regWrData[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware sets win over software clears
        if (scanEnd) begin
            next_endFlag = 1'b1;
            if (endIntEnable) begin
                next_irqStatus[IRQ_SCAN_END_BIT] = 1'b1;
            end
        end
        if (trigLost) begin
            next_irqStatus[IRQ_TRIG_LOST_BIT] = 1'b1;
        end
        next_irq = |(next_irqStatus & next_irqMask);

        next_regRdData = '0;
        if (regRd) begin
            case (regAddr)
                CONVERTER_CONTROL_ADDR: begin
                    next_regRdData[CTRL_START_BIT] = startBit;
                    next_regRdData[CTRL_SCAN_MODE_BIT] = scanMode;
                    next_regRdData[CTRL_AUTOCLEAR_BIT] = autoClear;
                    next_regRdData[CTRL_END_IE_BIT] = endIntEnable;
                    next_regRdData[CTRL_TRIG_EN_BIT] = trigEnable;
                end
                SCAN_STATUS_ADDR: begin
                    next_regRdData[STATUS_END_FLAG_BIT] = endFlag;
                end
                CHANNEL_SELECT_MASK_ADDR: begin
                    next_regRdData = chanMask;
                end
                IRQ_STATUS_ADDR: begin
                    next_regRdData[IRQ_W-1:0] = irqStatus;
                end
                IRQ_MASK_ADDR: begin
                    next_regRdData[IRQ_W-1:0] = irqMask;
                end
                default: begin
                    if (isResultAddr(regAddr)) begin
                        next_regRdData[RES_W-1:0] = result[resultIndex(regAddr)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ASC_IDLE;
            startBit <= 1'b0;
            scanMode <= 1'b0;
            autoClear <= 1'b0;
            endIntEnable <= 1'b0;
            trigEnable <= 1'b0;
            endFlag <= 1'b0;
            chanMask <= CHANNEL_MASK_RESET;
            irqStatus <= '0;
            irqMask <= IRQ_MASK_RESET;
            convCount <= '0;
            adcChannel <= '0;
            adcConvert <= 1'b0;
            result <= '{default: '0};
            regRdData <= '0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            startBit <= next_startBit;
            scanMode <= next_scanMode;
            autoClear <= next_autoClear;
            endIntEnable <= next_endIntEnable;
            trigEnable <= next_trigEnable;
            endFlag <= next_endFlag;
            chanMask <= next_chanMask;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            convCount <= next_convCount;
            adcChannel <= next_adcChannel;
            adcConvert <= next_adcConvert;
            result <= next_result;
            regRdData <= next_regRdData;
            irq <= next_irq;
        end
    end
endmodule : asc_scan_controller
`default_nettype wire

// *** logic/asc_pkg.sv ***
`default_nettype none
package asc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int RES_W = 12;
    localparam int CHAN_N = 16;
    localparam int CHAN_W = 4;
    localparam int TRIG_N = 5;
    localparam int IRQ_W = 2;

    // Register addresses
    localparam logic [ADDR_W-1:0] CONVERTER_CONTROL_ADDR = 32'hFFFFD400;
    localparam logic [ADDR_W-1:0] SCAN_STATUS_ADDR = 32'hFFFFD404;
    localparam logic [ADDR_W-1:0] CHANNEL_SELECT_MASK_ADDR = 32'hFFFFD408;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 32'hFFFFD40C;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 32'hFFFFD410;
    localparam logic [ADDR_W-1:0] RESULT_BASE_ADDR = 32'hFFFFD440;
    localparam int RESULT_STRIDE_SHIFT = 2;

    // Control register fields
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_SCAN_MODE_BIT = 6;
    localparam int CTRL_AUTOCLEAR_BIT = 5;
    localparam int CTRL_END_IE_BIT = 4;
    localparam int CTRL_TRIG_EN_BIT = 1;

    // Status and interrupt fields
    localparam int STATUS_END_FLAG_BIT = 0;
    localparam int IRQ_SCAN_END_BIT = 0;
    localparam int IRQ_TRIG_LOST_BIT = 1;

    // Reset values
    localparam logic [DATA_W-1:0] CHANNEL_MASK_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

    // Dedicated sample-and-hold channels 0..2 and 8..10
    localparam logic [CHAN_N-1:0] DEDICATED_HOLD_MASK = 16'h0707;
    localparam logic [CHAN_W-1:0] UPPER_GROUP_FIRST = 4'h8;

    // Conversion time per channel
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CONV_TIME_PS = 1250000;
    localparam int CONV_CYCLES = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

    typedef enum logic [1:0] {
        ASC_IDLE = 2'b00,
        ASC_SAMPLE = 2'b01,
        ASC_CONVERT = 2'b10
    } asc_state_type;
endpackage : asc_pkg
`default_nettype wire

// *** logic/asc_trigger_detect.sv ***
`default_nettype none
module asc_trigger_detect (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Active-low trigger lines
    input wire logic [asc_pkg::TRIG_N-1:0] trig_n,
    // One-cycle start pulse on any falling edge
    output logic trigPulse
);
    import asc_pkg::*;

    logic [TRIG_N-1:0] prev_n;
    logic [TRIG_N-1:0] fall;
    logic next_trigPulse;

    generate
        for (genvar i = 0; i < TRIG_N; i++) begin : g_edge
            assign fall[i] = prev_n[i] & ~trig_n[i];
        end
    endgenerate

    always_comb begin
        next_trigPulse = |fall;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev_n <= '1;
            trigPulse <= 1'b0;
        end else begin
            prev_n <= trig_n;
            trigPulse <= next_trigPulse;
        end
    end
endmodule : asc_trigger_detect
`default_nettype wire

// *** logic/asc_hold_control.sv ***
`default_nettype none
module asc_hold_control (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Scan sequencing
    input wire logic scanStart,
    input wire logic [asc_pkg::CHAN_N-1:0] scanMask,
    input wire logic sampleNow,
    input wire logic [asc_pkg::CHAN_W-1:0] sampleChannel,
    // Sample-and-hold strobes
    output logic [asc_pkg::CHAN_N-1:0] holdDedicated,
    output logic holdLowGroup,
    output logic holdHighGroup
);
    import asc_pkg::*;

    function automatic logic isDedicated(input logic [CHAN_W-1:0] ch);
        isDedicated = DEDICATED_HOLD_MASK[ch];
    endfunction

    logic [CHAN_N-1:0] next_holdDedicated;
    logic next_holdLowGroup;
    logic next_holdHighGroup;

    // All selected dedicated channels are held at the same instant
    generate
        for (genvar i = 0; i < CHAN_N; i++) begin : g_ded
            assign next_holdDedicated[i] = scanStart & scanMask[i] & isDedicated(CHAN_W'(i));
        end
    endgenerate

    // Shared holds serve the rest of each group, one channel at a time
    always_comb begin
        next_holdLowGroup = sampleNow & ~isDedicated(sampleChannel) & (sampleChannel < UPPER_GROUP_FIRST);
        next_holdHighGroup = sampleNow & ~isDedicated(sampleChannel) & (sampleChannel >= UPPER_GROUP_FIRST);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            holdDedicated <= '0;
            holdLowGroup <= 1'b0;
            holdHighGroup <= 1'b0;
        end else begin
            holdDedicated <= next_holdDedicated;
            holdLowGroup <= next_holdLowGroup;
            holdHighGroup <= next_holdHighGroup;
        end
    end
endmodule : asc_hold_control
`default_nettype wire

// *** dv/asc_scan_checker.sv ***
`default_nettype none
module asc_scan_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [asc_pkg::ADDR_W-1:0] regAddr,
    input wire logic regRd,
    input wire logic [asc_pkg::DATA_W-1:0] regRdData,
    // Front end
    input wire logic [asc_pkg::CHAN_W-1:0] adcChannel,
    input wire logic adcConvert,
    input wire logic [asc_pkg::CHAN_N-1:0] holdDedicated,
    input wire logic holdLowGroup,
    input wire logic holdHighGroup
);
    timeunit 1ns;
    timeprecision 100ps;
    import asc_pkg::*;
    logic [8:0] chCnt;
    logic [8:0] next_chCnt;
    logic [CHAN_W-1:0] chLast;
    logic convLast;
    // Cycles spent on the previous cycle's channel, minus one
    always_comb begin
        next_chCnt = 9'h000;
        if (adcConvert && convLast && adcChannel == chLast) begin
            next_chCnt = chCnt + 9'h001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            chCnt <= 9'h000;
            chLast <= 4'h0;
            convLast <= 1'b0;
        end else begin
            chCnt <= next_chCnt;
            chLast <= adcChannel;
            convLast <= adcConvert;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    AST_RESULT_WIDTH: assert property (
        $past(regRd) && $past(regAddr) >= RESULT_BASE_ADDR |-> regRdData[15:12] == 4'h0)
        else $error("result upper bits set");
    AST_READ_ONE_CYCLE: assert property (
        !$past(regRd) |-> regRdData == 16'h0000) else $error("read data outside answer cycle");
    AST_DEDICATED_ONLY: assert property (
        (holdDedicated & ~DEDICATED_HOLD_MASK) == 16'h0000) else $error("hold on shared channel");
    AST_DEDICATED_PULSE: assert property (
        holdDedicated != 16'h0000 |=> holdDedicated == 16'h0000 && adcConvert)
        else $error("dedicated hold not a pulse");
    AST_LOW_GROUP: assert property (
        holdLowGroup |-> adcConvert && adcChannel inside {[4'h3:4'h7]}) else $error("low group hold");
    AST_HIGH_GROUP: assert property (
        holdHighGroup |-> adcConvert && adcChannel inside {[4'hB:4'hF]}) else $error("high group hold");
    AST_CHANNEL_HOLD: assert property (
        $rose(adcConvert) |=> (!adcConvert || $stable(adcChannel)) [*8]) else $error("channel moved");
    AST_CONV_SPAN: assert property (
        adcConvert && $past(adcConvert) && adcChannel != $past(adcChannel)
        |-> $past(chCnt) == 9'(CONV_CYCLES - 1)) else $error("channel time wrong");
    AST_CONV_BOUND: assert property (
        adcConvert |-> chCnt <= 9'(CONV_CYCLES)) else $error("channel overran");
    AST_GROUP_PULSE: assert property (
        holdLowGroup || holdHighGroup |=> !holdLowGroup && !holdHighGroup)
        else $error("group hold not a pulse");
    AST_ASCENDING: assert property (
        adcConvert && $past(adcConvert) && adcChannel != $past(adcChannel)
        |-> adcChannel > $past(adcChannel)) else $error("channel order");
endmodule // asc_scan_checker
bind asc_scan_controller asc_scan_checker chk_u (
    .core_clk(core_clk),
    .srst(srst),
    .regAddr(regAddr),
    .regRd(regRd),
    .regRdData(regRdData),
    .adcChannel(adcChannel),
    .adcConvert(adcConvert),
    .holdDedicated(holdDedicated),
    .holdLowGroup(holdLowGroup),
    .holdHighGroup(holdHighGroup)
);
`default_nettype wire

// *** dv/asc_analog_model.sv ***
`default_nettype none
module asc_analog_model (
    // Clock
    input wire logic core_clk,
    // Front end
    input wire logic [asc_pkg::CHAN_W-1:0] adcChannel,
    input wire logic adcConvert,
    output logic [asc_pkg::RES_W-1:0] adcData,
    // Bench control
    input wire logic [7:0] salt,
    input wire logic [asc_pkg::TRIG_N-1:0] fire,
    // Trigger lines, active low
    output logic [asc_pkg::TRIG_N-1:0] trigLine_n
);
    timeunit 1ns;
    timeprecision 100ps;
    import asc_pkg::*;
    logic [TRIG_N-1:0] hold1 = 5'h00;
    logic [TRIG_N-1:0] hold2 = 5'h00;
    // Outside a conversion the value is not held, so show its inverse
    assign adcData = adcConvert ? {adcChannel, salt} : ~{adcChannel, salt};
    always @(posedge core_clk) begin
        hold1 <= fire;
        hold2 <= hold1;
    end
    // Lines idle high; a request pulls one low for two cycles
    assign trigLine_n = ~(hold1 | hold2);
endmodule // asc_analog_model
`default_nettype wire

// *** dv/asc_scan_controller_tb_top.sv ***
`default_nettype none
module asc_scan_controller_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import asc_pkg::*;
    logic core_clk;
    logic srst;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic regWr;
    logic regRd;
    logic [DATA_W-1:0] regRdData;
    logic [TRIG_N-1:0] trigLine_n;
    logic [TRIG_N-1:0] fire;
    logic [7:0] salt;
    logic [RES_W-1:0] adcData;
    logic [CHAN_W-1:0] adcChannel;
    logic adcConvert;
    logic [CHAN_N-1:0] holdDedicated;
    logic holdLowGroup;
    logic holdHighGroup;
    logic irq;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int chs[3] = '{3, 4, 11};

    asc_scan_controller dut_u (
        .core_clk(core_clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .timerTriggerA_n(trigLine_n[0]), .timerTriggerZero_n(trigLine_n[1]),
        .timerTriggerFourA_n(trigLine_n[2]), .timerTriggerFourB_n(trigLine_n[3]),
        .externalTriggerPin_n(trigLine_n[4]),
        .adcData(adcData), .adcChannel(adcChannel), .adcConvert(adcConvert),
        .holdDedicated(holdDedicated), .holdLowGroup(holdLowGroup), .holdHighGroup(holdHighGroup),
        .irq(irq)
    );
    asc_analog_model model_u (
        .core_clk(core_clk), .adcChannel(adcChannel), .adcConvert(adcConvert), .adcData(adcData),
        .salt(salt), .fire(fire), .trigLine_n(trigLine_n)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdChk(input string name, input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        logic [15:0] v;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        v = regRdData;
        chk(name, exp, v);
        @(posedge core_clk);
    endtask
    task automatic waitConv(input logic lvl, input int lim);
        int k;
        k = 0;
        // Step off the edge so a level launched there is settled
        #1;
        while (adcConvert !== lvl && k < lim) begin
            idle(1);
            k++;
        end
        chk("convert", {15'h0000, lvl}, {15'h0000, adcConvert});
    endtask
    function automatic logic [ADDR_W-1:0] resAddr(input int i);
        return RESULT_BASE_ADDR + ADDR_W'(i << RESULT_STRIDE_SHIFT);
    endfunction
    function automatic logic [15:0] expRes(input int i, input logic [7:0] s);
        return {4'h0, 4'(i), s};
    endfunction

    initial begin
        srst = 1'b1;
        regAddr = 32'h00000000;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        fire = 5'h00;
        salt = 8'h11;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        // Reset values and an unmapped place
        rdChk("control", CONVERTER_CONTROL_ADDR, 16'h0000);
        rdChk("mask", CHANNEL_SELECT_MASK_ADDR, CHANNEL_MASK_RESET);
        rdChk("irq mask", IRQ_MASK_ADDR, 16'h0000);
        wr(32'hFFFFD420, 16'hFFFF);
        rdChk("unmapped", 32'hFFFFD420, 16'h0000);
        // Single scan of the first four channels, end interrupt on
        wr(CHANNEL_SELECT_MASK_ADDR, 16'h000F);
        wr(IRQ_MASK_ADDR, 16'h0001);
        wr(CONVERTER_CONTROL_ADDR, 16'h0090);
        waitConv(1'b1, 5);
        waitConv(1'b0, 700);
        idle(20);
        chk("stopped", 16'h0000, {15'h0000, adcConvert});
        rdChk("control", CONVERTER_CONTROL_ADDR, 16'h0010);
        rdChk("status", SCAN_STATUS_ADDR, 16'h0001);
        chk("irq", 16'h0001, {15'h0000, irq});
        for (int i = 0; i < 5; i++) begin
            rdChk("result", resAddr(i), i < 4 ? expRes(i, 8'h11) : 16'h0000);
        end
        wr(SCAN_STATUS_ADDR, 16'h0001);
        rdChk("status", SCAN_STATUS_ADDR, 16'h0001);
        wr(SCAN_STATUS_ADDR, 16'h0000);
        rdChk("status", SCAN_STATUS_ADDR, 16'h0000);
        wr(IRQ_STATUS_ADDR, 16'h0001);
        idle(1);
        chk("irq", 16'h0000, {15'h0000, irq});
        // Readout with and without auto-clear
        rdChk("result kept", resAddr(1), expRes(1, 8'h11));
        rdChk("result kept", resAddr(1), expRes(1, 8'h11));
        wr(CONVERTER_CONTROL_ADDR, 16'h0020);
        rdChk("result read", resAddr(0), expRes(0, 8'h11));
        rdChk("result cleared", resAddr(0), 16'h0000);
        // End interrupt disabled
        wr(CHANNEL_SELECT_MASK_ADDR, 16'h0001);
        wr(CONVERTER_CONTROL_ADDR, 16'h0080);
        waitConv(1'b1, 5);
        waitConv(1'b0, 200);
        rdChk("status", SCAN_STATUS_ADDR, 16'h0001);
        rdChk("irq status", IRQ_STATUS_ADDR, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        wr(SCAN_STATUS_ADDR, 16'h0000);
        // Continuous scan over the shared holds of both groups
        salt <= 8'h22;
        wr(CHANNEL_SELECT_MASK_ADDR, 16'h0818);
        wr(CONVERTER_CONTROL_ADDR, 16'h00C0);
        waitConv(1'b1, 5);
        waitConv(1'b0, 600);
        waitConv(1'b1, 5);
        salt <= 8'h33;
        waitConv(1'b0, 600);
        waitConv(1'b1, 5);
        rdChk("control", CONVERTER_CONTROL_ADDR, 16'h00C0);
        for (int i = 0; i < 3; i++) begin
            rdChk("result", resAddr(chs[i]), expRes(chs[i], 8'h33));
        end
        wr(CONVERTER_CONTROL_ADDR, 16'h0040);
        idle(3);
        chk("halted", 16'h0000, {15'h0000, adcConvert});
        idle(300);
        chk("halted", 16'h0000, {15'h0000, adcConvert});
        rdChk("control", CONVERTER_CONTROL_ADDR, 16'h0040);
        // Triggers ignored, then accepted
        wr(CHANNEL_SELECT_MASK_ADDR, 16'h0001);
        wr(CONVERTER_CONTROL_ADDR, 16'h0000);
        for (int i = 0; i < TRIG_N; i++) begin
            fire <= 5'h01 << i;
            idle(1);
            fire <= 5'h00;
            idle(10);
            chk("ignored", 16'h0000, {15'h0000, adcConvert});
        end
        wr(CONVERTER_CONTROL_ADDR, 16'h0002);
        for (int i = 0; i < TRIG_N; i++) begin
            fire <= 5'h01 << i;
            idle(1);
            fire <= 5'h00;
            waitConv(1'b1, 8);
            waitConv(1'b0, 200);
            idle(2);
        end
        rdChk("control", CONVERTER_CONTROL_ADDR, 16'h0002);
        report_and_stop();
    end
endmodule // asc_scan_controller_tb_top
`default_nettype wire
